/* common/purs_pkg.sv */
// Purpose: Shared constants for the power-up reset sequencer
// Assumes: 100 MHz system clock; RC tick and oscillator pulses are synchronous inputs
// Notes: Delay timer counts RC ticks; settle timer counts oscillator edges
package purs_pkg;
   localparam int CLK_MHZ = 100;
   // Nominal power-up delay in milliseconds
   localparam int PWRUP_DELAY_MS = 96;
   // RC oscillator tick rate, kHz (plain default)
   localparam int RC_TICK_KHZ = 32;
   // RC ticks for the power-up delay
   localparam int PWRUP_TICKS_DEF = PWRUP_DELAY_MS * RC_TICK_KHZ;
   localparam int PWRUP_CNT_W = 20;
   // Oscillator periods for the settle delay
   localparam int SETTLE_PERIODS = 1024;
   localparam int SETTLE_CNT_W = 11;
   // Clock out period in input clock periods
   localparam int CLKOUT_DIV = 4;
   localparam logic [1:0] CLKOUT_HALF = 2'h1;

   typedef enum logic [1:0] {
      PURS_OFF = 2'b00,
      PURS_WAIT_MASTER_CLEAR_PIN = 2'b01,
      PURS_TIMING = 2'b10,
      PURS_RUN = 2'b11
   } purs_state_t;

   typedef enum logic [1:0] {
      PURS_OSC_CRYSTAL = 2'b00,
      PURS_OSC_LOWFREQ = 2'b01,
      PURS_OSC_EXTCLK = 2'b10,
      PURS_OSC_OTHER = 2'b11
   } purs_osc_mode_t;
endpackage

/* rtl/purs_delay_timer.sv */
// Purpose: Power-up delay timer counting RC oscillator ticks
// Assumes: rc_tick is a one-cycle pulse from the internal RC oscillator
// Notes: Expired holds until a new start
`timescale 1ns/1ps
`default_nettype none
module purs_delay_timer import purs_pkg::*; #(
   parameter logic [PWRUP_CNT_W-1:0] TICKS = PWRUP_CNT_W'(PWRUP_TICKS_DEF)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic rc_tick,
   // Status
   output logic expired
);
   logic [PWRUP_CNT_W-1:0] cnt_reg, cnt_next;
   logic run_reg, run_next;
   logic done_reg, done_next;

   always_comb begin
      cnt_next = cnt_reg;
      run_next = run_reg;
      done_next = done_reg;
      if (start) begin
         cnt_next = '0;
         run_next = 1'b1;
         done_next = 1'b0;
      end else if (run_reg && rc_tick) begin
         if (cnt_reg == TICKS - PWRUP_CNT_W'(1)) begin
            run_next = 1'b0;
            done_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + PWRUP_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         done_reg <= done_next;
      end
   end

   assign expired = done_reg;
endmodule
`default_nettype wire

/* rtl/purs_settle_timer.sv */
// Purpose: Oscillator settle timer counting oscillator input pulses
// Assumes: osc_pulse is a one-cycle pulse per oscillator period
// Notes: Counts only while amplitude is above the input thresholds
`timescale 1ns/1ps
`default_nettype none
module purs_settle_timer import purs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic osc_pulse,
   input wire logic osc_amp_ok,
   // Status
   output logic expired
);
   logic [SETTLE_CNT_W-1:0] cnt_reg, cnt_next;
   logic run_reg, run_next;
   logic done_reg, done_next;

   always_comb begin
      cnt_next = cnt_reg;
      run_next = run_reg;
      done_next = done_reg;
      if (start) begin
         cnt_next = '0;
         run_next = 1'b1;
         done_next = 1'b0;
      end else if (run_reg && osc_pulse && osc_amp_ok) begin
         if (cnt_reg == SETTLE_CNT_W'(SETTLE_PERIODS - 1)) begin
            run_next = 1'b0;
            done_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + SETTLE_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         done_reg <= done_next;
      end
   end

   assign expired = done_reg;
endmodule
`default_nettype wire

/* rtl/purs_sequencer.sv */
// Purpose: Power-up reset sequencer deciding when the core leaves reset
// Assumes: All inputs synchronous to clk; supply_ok is the supply-on detector level
// Notes: Core reset and clock output come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module purs_sequencer import purs_pkg::*; #(
   parameter logic [PWRUP_CNT_W-1:0] PWRUP_TICKS = PWRUP_CNT_W'(PWRUP_TICKS_DEF)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Supply and master clear
   input wire logic supply_ok,
   input wire logic master_clear_pin,
   input wire logic master_clear_pin_tied,
   // Oscillator
   input wire logic [1:0] osc_mode,
   input wire logic rc_tick,
   input wire logic osc_input_pin,
   input wire logic osc_amp_ok,
   input wire logic sleep_wake,
   // Outputs
   output logic core_reset,
   output logic osc_input_oe,
   output logic osc_output_pin,
   output logic osc_output_oe,
   output logic supply_drop_reset
);
   purs_state_t state_reg, state_next;
   logic supply_reg, master_clear_pin_reg, osc_in_reg;
   logic rst_out_reg, rst_out_next;
   logic [1:0] div_reg, div_next;
   logic clkout_reg, clkout_next;
   logic pwr_start, settle_start;
   logic pwr_done, settle_done;
   logic osc_pulse, supply_rise, supply_fall, master_clear_pin_rise;
   logic wake_crystal, ext_clk;

   function automatic logic rising(input logic now, input logic prev);
      return now && !prev;
   endfunction

   assign supply_rise = rising(supply_ok, supply_reg);
   assign supply_fall = rising(supply_reg, supply_ok);
   assign master_clear_pin_rise = rising(master_clear_pin, master_clear_pin_reg);
   assign osc_pulse = rising(osc_input_pin, osc_in_reg);
   assign ext_clk = (osc_mode == PURS_OSC_EXTCLK);
   assign wake_crystal = sleep_wake && (state_reg == PURS_RUN) &&
                         ((osc_mode == PURS_OSC_CRYSTAL) || (osc_mode == PURS_OSC_LOWFREQ));

   // Timer starts
   always_comb begin
      pwr_start = 1'b0;
      if (supply_ok && state_reg == PURS_OFF && master_clear_pin_tied && supply_rise)
         pwr_start = 1'b1;
      else if (supply_ok && state_reg == PURS_WAIT_MASTER_CLEAR_PIN && master_clear_pin_rise)
         pwr_start = 1'b1;
   end
   assign settle_start = pwr_start || wake_crystal;

   // Sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PURS_OFF: begin
            if (supply_ok && master_clear_pin_tied && supply_rise)
               state_next = PURS_TIMING;
            else if (supply_ok && !master_clear_pin_tied)
               state_next = PURS_WAIT_MASTER_CLEAR_PIN;
         end
         PURS_WAIT_MASTER_CLEAR_PIN: begin
            if (pwr_start)
               state_next = PURS_TIMING;
         end
         PURS_TIMING: begin
            if (pwr_done && settle_done)
               state_next = PURS_RUN;
         end
         PURS_RUN: begin
            if (wake_crystal)
               state_next = PURS_TIMING;
         end
         default: state_next = PURS_OFF;
      endcase
      if (!supply_ok)
         state_next = PURS_OFF;
   end

   // Wake from sleep needs only the settle timer
   logic wake_reg, wake_next;
   always_comb begin
      wake_next = wake_reg;
      if (wake_crystal)
         wake_next = 1'b1;
      else if (pwr_start || state_next != PURS_TIMING)
         wake_next = 1'b0;
   end

   logic pwr_ok;
   assign pwr_ok = pwr_done || wake_reg;

   always_comb begin
      rst_out_next = 1'b1;
      if (supply_ok && state_reg == PURS_TIMING && pwr_ok && settle_done && !settle_start)
         rst_out_next = 1'b0;
      else if (supply_ok && state_reg == PURS_RUN && !wake_crystal)
         rst_out_next = 1'b0;
      if (supply_rise || supply_fall)
         rst_out_next = 1'b1;
   end

   // Clock out, four input periods
   always_comb begin
      div_next = div_reg;
      clkout_next = clkout_reg;
      if (!ext_clk) begin
         div_next = 2'h0;
         clkout_next = 1'b0;
      end else if (osc_pulse) begin
         div_next = div_reg + 2'h1;
         if (div_reg == CLKOUT_HALF || div_reg == 2'h3)
            clkout_next = !clkout_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= PURS_OFF;
         supply_reg <= 1'b0;
         master_clear_pin_reg <= 1'b0;
         osc_in_reg <= 1'b0;
         rst_out_reg <= 1'b1;
         div_reg <= 2'h0;
         clkout_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         supply_reg <= supply_ok;
         master_clear_pin_reg <= master_clear_pin;
         osc_in_reg <= osc_input_pin;
         rst_out_reg <= rst_out_next;
         div_reg <= div_next;
         clkout_reg <= clkout_next;
         wake_reg <= wake_next;
      end
   end

   purs_delay_timer #(
      .TICKS(PWRUP_TICKS)
   ) u_pwr (
      .clk(clk),
      .rst(rst),
      .start(pwr_start),
      .rc_tick(rc_tick),
      .expired(pwr_done)
   );

   purs_settle_timer u_settle (
      .clk(clk),
      .rst(rst),
      .start(settle_start),
      .osc_pulse(osc_pulse),
      .osc_amp_ok(osc_amp_ok),
      .expired(settle_done)
   );

   assign core_reset = rst_out_reg;
   assign supply_drop_reset = !supply_reg;
   assign osc_input_oe = 1'b0;
   assign osc_output_pin = clkout_reg;
   assign osc_output_oe = ext_clk;
endmodule
`default_nettype wire

/* testbench/purs_seq_properties.sv */
// Purpose: Port checks for the reset sequencer
// Assumes: Inputs change away from the rising edge
// Notes: Helper counters may overcount; osc_cnt wraps after 4096 pulses, rc_cnt saturates
`timescale 1ns/1ps
`default_nettype none
module purs_seq_properties import purs_pkg::*; #(
   parameter logic [PWRUP_CNT_W-1:0] PWRUP_TICKS = PWRUP_CNT_W'(PWRUP_TICKS_DEF)
) (
   // Clock, reset and inputs
   input wire logic clk,
   input wire logic rst,
   input wire logic supply_ok,
   input wire logic [1:0] osc_mode,
   input wire logic rc_tick,
   input wire logic osc_input_pin,
   input wire logic osc_amp_ok,
   input wire logic sleep_wake,
   // Outputs
   input wire logic core_reset,
   input wire logic osc_input_oe,
   input wire logic osc_output_pin,
   input wire logic osc_output_oe,
   input wire logic supply_drop_reset
);
   logic osc_q;
   logic [11:0] osc_cnt;
   logic [19:0] rc_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_q <= 1'b0;
         osc_cnt <= 12'h0;
         rc_cnt <= 20'h0;
      end else begin
         osc_q <= osc_input_pin;
         osc_cnt <= (sleep_wake || !supply_ok) ? 12'h0 : osc_cnt + 12'(osc_input_pin && !osc_q && osc_amp_ok);
         rc_cnt <= !supply_ok ? 20'h0 : rc_cnt + 20'(rc_tick && rc_cnt != 20'hFFFFF);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wake(logic m);
      sleep_wake && supply_ok && !core_reset && osc_mode[1] == m;
   endsequence
   AST_IN_HIZ: assert property (osc_input_oe == 1'b0) else $error("input pin driven");
   AST_OUT_OE: assert property (osc_output_oe == (osc_mode == 2'h2)) else $error("clock out enable wrong");
   AST_OUT_IDLE: assert property ((osc_mode != 2'h2) [*2] |-> !osc_output_pin) else $error("clock out active");
   AST_SUPPLY_FALL: assert property ($fell(supply_ok) |-> ##[0:2] core_reset) else $error("no reset on fall");
   AST_LOW_HOLD: assert property (!supply_ok [*2] |-> core_reset && supply_drop_reset) else $error("low supply");
   AST_OSC_DONE: assert property ($fell(core_reset) |-> osc_cnt >= 12'h400) else $error("settle cut short");
   AST_RC_DONE: assert property ($fell(core_reset) |-> rc_cnt >= 20'(PWRUP_TICKS)) else $error("delay cut short");
   AST_WAKE_XTAL: assert property (s_wake(1'b0) |=> core_reset) else $error("wake not held");
   AST_WAKE_EXT: assert property (s_wake(1'b1) |=> !core_reset) else $error("wake not ignored");
endmodule
bind purs_sequencer purs_seq_properties #(.PWRUP_TICKS(PWRUP_TICKS)) i_purs_seq_properties (.clk(clk), .rst(rst),
   .supply_ok(supply_ok), .osc_mode(osc_mode), .rc_tick(rc_tick), .osc_input_pin(osc_input_pin),
   .osc_amp_ok(osc_amp_ok), .sleep_wake(sleep_wake), .core_reset(core_reset), .osc_input_oe(osc_input_oe),
   .osc_output_pin(osc_output_pin), .osc_output_oe(osc_output_oe), .supply_drop_reset(supply_drop_reset));
`default_nettype wire

/* testbench/purs_far_model.sv */
// Purpose: Oscillator and RC tick source
// Assumes: Changes on the falling clock edge
// Notes: Oscillator stands low when disabled
`timescale 1ns/1ps
`default_nettype none
module purs_far_model (
   // Clock and control
   input wire logic clk,
   input wire logic osc_en,
   input wire logic [15:0] rc_div,
   // Sources
   output logic osc_input_pin,
   output logic rc_tick
);
   logic [1:0] ph = 2'h0;
   logic [15:0] rc_cnt = 16'h0;
   initial osc_input_pin = 1'b0;
   initial rc_tick = 1'b0;
   always @(negedge clk) begin
      ph <= ph + 2'h1;
      osc_input_pin <= osc_en && ph[1];
      // Tick source apart from the oscillator
      rc_cnt <= (rc_cnt >= rc_div) ? 16'h0 : rc_cnt + 16'h1;
      rc_tick <= (rc_cnt == rc_div);
   end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Scenario bench for the reset sequencer
// Assumes: Small power-up tick count
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import purs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic supply_ok = 1'b0, master_clear_pin = 1'b1, master_clear_pin_tied = 1'b1, osc_amp_ok = 1'b1, sleep_wake = 1'b0;
   logic osc_en = 1'b1;
   logic [1:0] osc_mode = 2'h0;
   logic [15:0] rc_div = 16'h7;
   wire logic rc_tick, osc_input_pin, core_reset, osc_input_oe, osc_output_pin, osc_output_oe, supply_drop_reset;
   int bad_count = 0;
   int n_tests = 0;
   int n;
   purs_far_model i_purs_far_model (.clk(clk), .osc_en(osc_en), .rc_div(rc_div), .osc_input_pin(osc_input_pin),
      .rc_tick(rc_tick));
   purs_sequencer #(.PWRUP_TICKS(PWRUP_CNT_W'(4))) i_purs_sequencer (.clk(clk), .rst(rst), .supply_ok(supply_ok),
      .master_clear_pin(master_clear_pin), .master_clear_pin_tied(master_clear_pin_tied), .osc_mode(osc_mode), .rc_tick(rc_tick),
      .osc_input_pin(osc_input_pin), .osc_amp_ok(osc_amp_ok), .sleep_wake(sleep_wake), .core_reset(core_reset),
      .osc_input_oe(osc_input_oe), .osc_output_pin(osc_output_pin), .osc_output_oe(osc_output_oe),
      .supply_drop_reset(supply_drop_reset));
   initial forever #5 clk = ~clk;
   task automatic check(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s exp %b got %b", what, exp, got);
      end
   endtask
   task automatic wait_rel(input int lim);
      n = 0;
      while (core_reset !== 1'b0 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic supply_cycle();
      supply_ok = 1'b0;
      repeat (3) @(negedge clk);
      check("low_reset", 1'b1, core_reset);
      check("drop_flag", 1'b1, supply_drop_reset);
      supply_ok = 1'b1;
   endtask
   task automatic t_tied();
      supply_ok = 1'b1;
      wait_rel(6000);
      check("tied_release", 1'b0, core_reset);
      check("tied_late", 1'b1, n >= 4090);
      check("drop_clear", 1'b0, supply_drop_reset);
      $display("done tied");
   endtask
   task automatic t_slow_rc();
      rc_div = 16'd1499;
      supply_cycle();
      repeat (5000) @(negedge clk);
      check("slow_held", 1'b1, core_reset);
      wait_rel(2500);
      check("slow_release", 1'b0, core_reset);
      $display("done slow_rc");
   endtask
   task automatic t_amp();
      rc_div = 16'h7;
      osc_amp_ok = 1'b0;
      supply_cycle();
      repeat (6000) @(negedge clk);
      check("amp_held", 1'b1, core_reset);
      osc_amp_ok = 1'b1;
      wait_rel(6000);
      check("amp_release", 1'b0, core_reset);
      $display("done amp");
   endtask
   task automatic t_master_clear_pin();
      master_clear_pin_tied = 1'b0;
      master_clear_pin = 1'b0;
      supply_cycle();
      repeat (5000) @(negedge clk);
      check("master_clear_pin_held", 1'b1, core_reset);
      master_clear_pin = 1'b1;
      wait_rel(6000);
      check("master_clear_pin_release", 1'b0, core_reset);
      $display("done master_clear_pin");
   endtask
   task automatic t_wake();
      int ni, no;
      logic pi, po;
      ni = 0;
      no = 0;
      osc_mode = 2'h2;
      sleep_wake = 1'b1;
      @(negedge clk);
      sleep_wake = 1'b0;
      @(negedge clk);
      check("ext_wake", 1'b0, core_reset);
      check("out_oe", 1'b1, osc_output_oe);
      check("in_oe", 1'b0, osc_input_oe);
      pi = osc_input_pin;
      po = osc_output_pin;
      repeat (400) begin
         @(negedge clk);
         ni += int'(osc_input_pin && !pi);
         no += int'(osc_output_pin && !po);
         pi = osc_input_pin;
         po = osc_output_pin;
      end
      check("clkout_div", 1'b1, no * 4 >= ni - 4 && no * 4 <= ni + 4 && no > 0);
      osc_mode = 2'h0;
      @(negedge clk);
      sleep_wake = 1'b1;
      @(negedge clk);
      sleep_wake = 1'b0;
      @(negedge clk);
      check("xtal_wake", 1'b1, core_reset);
      wait_rel(6000);
      check("wake_release", 1'b0, core_reset);
      check("wake_late", 1'b1, n >= 4080);
      // Low-frequency crystal wake also reruns the settle count
      osc_mode = 2'h1;
      sleep_wake = 1'b1;
      @(negedge clk);
      sleep_wake = 1'b0;
      @(negedge clk);
      check("lf_wake", 1'b1, core_reset);
      wait_rel(6000);
      check("lf_release", 1'b0, core_reset);
      check("lf_late", 1'b1, n >= 4080);
      // Other mode ignores wake and keeps clock out idle
      osc_mode = 2'h3;
      sleep_wake = 1'b1;
      @(negedge clk);
      sleep_wake = 1'b0;
      @(negedge clk);
      check("other_wake", 1'b0, core_reset);
      check("other_oe", 1'b0, osc_output_oe);
      check("other_out", 1'b0, osc_output_pin);
      $display("done wake");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_tied();
      t_slow_rc();
      t_amp();
      t_master_clear_pin();
      t_wake();
      conclude();
   end
   initial begin
      #600000;
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
